// file: hdl/rdcfg_bank.sv
// Configuration register bank and position/velocity readout of the
// resolver converter. Assumes all inputs synchronous to clk_in, and a
// tracking loop outside that supplies angle, speed and raw fault events.
`timescale 1ns/1ps

//Contract
// - Mode pins 00 position, 01 velocity, 10 reserved, 11 configuration.
// - Configuration mode allows writing setup registers and reading all.
// - Excitation rate equals frequency word times clock over 2^15.
// - Excitation word powers up to the 10 kHz value at 8.192 MHz.
// - Resolution from pins in normal mode, control bits in configuration.
// - Position register loads on sample falling edge; bytes 0x80, 0x81.
// - Hysteresis on forces unused low position bits to zero.
// - Hysteresis off stores full 16-bit position at every resolution.
// - Velocity register loads on sample falling edge; bytes 0x82, 0x83.
// - Full-scale velocity codes 0x7FFF and 0x8000 at 16 bits.
// - Lower resolutions keep velocity MSB aligned, low bits ignored.
// - Signal loss threshold at 0x88, seven bits, powers up 2.2 V.
// - Overrange threshold at 0x89, seven bits, powers up 4.1 V.
// - Mismatch threshold at 0x8A, seven bits, powers up 380 mV.
// - Velocity LSB weight scales linearly with the master clock.
// - Written byte with MSB high is address, else data plus parity.
// - Readback MSB high when recomputed parity disagrees with stored.
// - Control register powers up to 0x7E.
// - Reading fault register in configuration mode clears latched faults.
module rdcfg_bank
  import rdcfg_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic mode_select_lo_in,
  input wire logic mode_select_hi_in,
  input wire logic resolution_select_lo_in,
  input wire logic resolution_select_hi_in,
  input wire logic sample_in,
  input wire logic [15:0] angle_in,
  input wire logic [15:0] speed_in,
  input wire logic [7:0] fault_in,
  input wire logic wr_strobe_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_strobe_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic [15:0] data_out,
  output logic config_mode_out,
  output logic [1:0] resolution_out,
  output logic [1:0] encoder_resolution_out,
  output logic hysteresis_out,
  output logic phase_lock_narrow_out,
  output logic excitation_out,
  output logic soft_reset_out,
  output logic fault_cleared_out,
  output logic [6:0] signal_loss_threshold_out,
  output logic [6:0] overrange_threshold_out,
  output logic [6:0] mismatch_threshold_out,
  output logic [6:0] amplitude_reset_max_out,
  output logic [6:0] amplitude_reset_min_out,
  output logic [6:0] tracking_high_threshold_out,
  output logic [6:0] tracking_low_threshold_out
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Mode pin decode
  function automatic rdcfg_mode_e decode_mode(input logic a0,
                                              input logic a1);
    rdcfg_mode_e m;
    m = MODE_RESERVED;
    unique case ({a0, a1})
      2'b00: m = MODE_POSITION;
      2'b01: m = MODE_VELOCITY;
      2'b10: m = MODE_RESERVED;
      2'b11: m = MODE_CONFIG;
    endcase
    return m;
  endfunction

  // Address to storage slot; IDX_NONE for anything not read/write
  function automatic logic [3:0] rw_index(input logic [7:0] a);
    logic [3:0] i;
    i = IDX_NONE;
    case (a)
      ADDR_LOSS_THR: i = IDX_LOSS;
      ADDR_OVER_THR: i = IDX_OVER;
      ADDR_MISM_THR: i = IDX_MISM;
      ADDR_AMP_MAX: i = IDX_AMAX;
      ADDR_AMP_MIN: i = IDX_AMIN;
      ADDR_TRK_HIGH: i = IDX_THIGH;
      ADDR_TRK_LOW: i = IDX_TLOW;
      ADDR_EXC_FREQ: i = IDX_FCW;
      ADDR_CONTROL: i = IDX_CTRL;
      default: i = IDX_NONE;
    endcase
    return i;
  endfunction

  // Power-up data bits of each slot
  function automatic logic [6:0] rw_reset(input logic [3:0] i);
    logic [6:0] v;
    v = 7'h00;
    case (i)
      IDX_LOSS: v = RST_LOSS;
      IDX_OVER: v = RST_OVER;
      IDX_MISM: v = RST_MISM;
      IDX_AMAX: v = RST_AMAX;
      IDX_AMIN: v = RST_AMIN;
      IDX_THIGH: v = RST_THIGH;
      IDX_TLOW: v = RST_TLOW;
      IDX_FCW: v = RST_FCW;
      IDX_CTRL: v = RST_CTRL;
      default: v = 7'h00;
    endcase
    return v;
  endfunction

  // Stored byte with recomputed parity flag in the MSB
  function automatic logic [7:0] readback(input logic [7:0] b);
    return {(^b[6:0]) != b[PARITY_POS], b[6:0]};
  endfunction

  // Mask of the bits that carry data at a given resolution code; zeros mark the unused low bits
  function automatic logic [15:0] res_mask(input logic [1:0] r);
    logic [15:0] m;
    m = 16'hffff;
    unique case (r)
      2'b00: m = 16'hffc0;
      2'b01: m = 16'hfff0;
      2'b10: m = 16'hfffc;
      2'b11: m = 16'hffff;
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0] cfg_q [0:RW_COUNT-1];
  logic [7:0] addr_q;
  logic [15:0] angle_q;
  logic [15:0] speed_q;
  logic [7:0] fault_q;
  logic [7:0] fault_d;
  logic sample_q;
  logic [EXC_ACC_W-1:0] acc_q;
  logic parity_err;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Mode, strobes and selected slot
  rdcfg_mode_e mode;
  wire cfg_mode = (mode == MODE_CONFIG);
  wire wr_take = clk_en_in & wr_strobe_in & cfg_mode;
  wire rd_take = clk_en_in & rd_strobe_in & cfg_mode;
  wire is_addr = wr_data_in[ADDR_FLAG_POS];
  wire data_wr = wr_take & ~is_addr;
  wire [3:0] sel_idx = rw_index(addr_q);
  wire sel_rw = (sel_idx != IDX_NONE);
  wire [7:0] sel_byte = sel_rw ? cfg_q[sel_idx] : 8'h00;
  wire fault_clr = rd_take & (addr_q == ADDR_FAULT);
  wire sample_fall = sample_q & ~sample_in;
  wire [7:0] ctrl = cfg_q[IDX_CTRL];
  wire hyst = ctrl[CTRL_HYST_POS];
  wire [6:0] frequency_control_word = cfg_q[IDX_FCW][6:0];
  assign mode = decode_mode(mode_select_lo_in, mode_select_hi_in);

  // Resolution code is {RESOLUTION_SELECT_LO, RESOLUTION_SELECT_HI}: 00=10 .. 11=16 bits
  wire [1:0] pin_res = {resolution_select_lo_in, resolution_select_hi_in};
  wire [1:0] reg_res = {ctrl[CTRL_RESOLUTION_SELECT_LO_POS], ctrl[CTRL_RESOLUTION_SELECT_HI_POS]};
  wire [1:0] res_d = cfg_mode ? reg_res : pin_res;
  wire [15:0] angle_d = hyst ? (angle_in & res_mask(res_d))
                             : angle_in;

  // Read data selection; write-only and unmapped addresses read zero
  logic [7:0] rd_value;
  always_comb
  begin
    rd_value = 8'h00;
    case (addr_q)
      ADDR_ANGLE_HI: rd_value = angle_q[15:8];
      ADDR_ANGLE_LO: rd_value = angle_q[7:0];
      ADDR_SPEED_HI: rd_value = speed_q[15:8];
      ADDR_SPEED_LO: rd_value = speed_q[7:0];
      ADDR_FAULT: rd_value = fault_q;
      default: rd_value = sel_rw ? readback(sel_byte) : 8'h00;
    endcase
  end

  // Continuous parity scan catches a corrupted slot at any time
  always_comb
  begin
    parity_err = 1'b0;
    for (int i = 0; i < RW_COUNT; i++)
      parity_err = parity_err | (^cfg_q[i]); // Odd weight marks a bad slot
  end

  // Sticky faults; a new event in the clearing cycle survives the clear
  wire [7:0] fault_set = fault_in | (8'(parity_err) << FAULT_PARITY_POS);
  assign fault_d = fault_clr ? fault_set
                             : (fault_q | fault_set);

  // ----------------------------------------------------------------------
  // Host register access
  // ----------------------------------------------------------------------
  // MSB high selects an address, low stores data with its parity
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      addr_q <= RST_ADDR;
      for (int i = 0; i < RW_COUNT; i++)
        cfg_q[i] <= {^rw_reset(4'(i)), rw_reset(4'(i))};
    end
    else if (wr_take)
    begin
      if (is_addr)
        addr_q <= wr_data_in;
      else if (sel_rw)
        cfg_q[sel_idx] <= {^wr_data_in[6:0], wr_data_in[6:0]};
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      rd_valid_out <= rd_take;
      if (rd_take)
        rd_data_out <= rd_value;
    end
  end

  // Fault latch and side-effect pulses
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      fault_q <= 8'h00;
      fault_cleared_out <= 1'b0;
      soft_reset_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      fault_q <= fault_d;
      fault_cleared_out <= fault_clr;
      soft_reset_out <= data_wr & (addr_q == ADDR_SOFT_RST);
    end
  end

  // ----------------------------------------------------------------------
  // Sampled position and velocity
  // ----------------------------------------------------------------------
  // Velocity arrives MSB aligned from the loop and is stored untouched,
  // so full-scale codes pass through at every resolution
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sample_q <= 1'b1;
      angle_q <= 16'h0000;
      speed_q <= 16'h0000;
    end
    else if (clk_en_in)
    begin
      sample_q <= sample_in;
      if (sample_fall)
      begin
        angle_q <= angle_d;
        speed_q <= speed_in;
      end
    end
  end

  // Normal mode output; reserved pins leave the last value in place
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      data_out <= 16'h0000;
    else if (clk_en_in && mode == MODE_POSITION)
      data_out <= angle_q;
    else if (clk_en_in && mode == MODE_VELOCITY)
      data_out <= speed_q;
  end

  // ----------------------------------------------------------------------
  // Excitation and control outputs
  // ----------------------------------------------------------------------
  // Accumulator MSB toggles at word * f_clk / 2^15; rate tracks clock
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      acc_q <= '0;
      config_mode_out <= 1'b0;
      resolution_out <= 2'b00;
    end
    else if (clk_en_in)
    begin
      acc_q <= acc_q + EXC_ACC_W'(frequency_control_word);
      config_mode_out <= cfg_mode;
      resolution_out <= res_d;
    end
  end

  // Control fields and thresholds straight from storage flops
  assign excitation_out = acc_q[EXC_ACC_W-1];
  assign encoder_resolution_out = ctrl[CTRL_ENC_LSB+1:CTRL_ENC_LSB];
  assign hysteresis_out = hyst;
  assign phase_lock_narrow_out = ctrl[CTRL_PHASE_POS];
  assign signal_loss_threshold_out = cfg_q[IDX_LOSS][6:0];
  assign overrange_threshold_out = cfg_q[IDX_OVER][6:0];
  assign mismatch_threshold_out = cfg_q[IDX_MISM][6:0];
  assign amplitude_reset_max_out = cfg_q[IDX_AMAX][6:0];
  assign amplitude_reset_min_out = cfg_q[IDX_AMIN][6:0];
  assign tracking_high_threshold_out = cfg_q[IDX_THIGH][6:0];
  assign tracking_low_threshold_out = cfg_q[IDX_TLOW][6:0];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  chk_mode_decode: assert property (
    clk_en_in |=> config_mode_out ==
      ($past(mode_select_lo_in) && $past(mode_select_hi_in)))
    else $error("config mode flag does not follow mode pins");

  chk_write_gate: assert property (
    clk_en_in && wr_strobe_in && !cfg_mode |=>
      $stable(addr_q) && $stable(ctrl) && $stable(frequency_control_word))
    else $error("register changed outside configuration mode");

  chk_exc_accum: assert property (
    clk_en_in |=> acc_q == EXC_ACC_W'($past(acc_q) + $past(frequency_control_word)))
    else $error("excitation accumulator step wrong");

  chk_power_up: assert property (
    $fell(reset_in) |-> ctrl == 8'h7e && frequency_control_word == 7'h28)
    else $error("control or frequency default wrong");

  chk_thr_defaults: assert property (
    $fell(reset_in) |-> signal_loss_threshold_out == RST_LOSS &&
      overrange_threshold_out == RST_OVER &&
      mismatch_threshold_out == RST_MISM)
    else $error("threshold default wrong");

  chk_pin_res: assert property (
    clk_en_in && !cfg_mode |=> resolution_out ==
      {$past(resolution_select_lo_in), $past(resolution_select_hi_in)})
    else $error("normal mode resolution not from pins");

  chk_angle_full: assert property (
    clk_en_in && sample_fall && !hyst |=> angle_q == $past(angle_in))
    else $error("position not captured in full");

  chk_angle_mask: assert property (
    clk_en_in && sample_fall && hyst |=>
      (angle_q & ~res_mask($past(res_d))) == 16'h0000 &&
      (angle_q | ~res_mask($past(res_d))) ==
      ($past(angle_in) | ~res_mask($past(res_d))))
    else $error("position low bits not forced to zero");

  chk_speed_hold: assert property (
    clk_en_in && !sample_fall |=> $stable(speed_q))
    else $error("velocity changed without sample edge");

  chk_addr_flag: assert property (
    wr_take && is_addr |=> addr_q == $past(wr_data_in))
    else $error("address byte not taken");

  chk_parity_read: assert property (
    rd_take && sel_rw |=> rd_valid_out &&
      rd_data_out == readback($past(sel_byte)))
    else $error("readback parity flag wrong");

  chk_fault_clear: assert property (
    fault_clr && fault_in == 8'h00 && !parity_err |=> fault_q == 8'h00)
    else $error("fault register not cleared by read");

  cov_ctrl_write: cover property (
    wr_take && is_addr && wr_data_in == ADDR_CONTROL ##1 data_wr);
  cov_fault_read: cover property (fault_clr && fault_q != 8'h00);
  cov_vel_sample: cover property (
    clk_en_in && sample_fall && mode == MODE_VELOCITY);

endmodule

// file: hdl/rdcfg_pkg.sv
// Constants shared by the converter configuration and readout bank.
// Assumes one 50 MHz clock and byte-wide host access in configuration mode.
package rdcfg_pkg;
  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_ANGLE_HI = 8'h80;
  localparam logic [7:0] ADDR_ANGLE_LO = 8'h81;
  localparam logic [7:0] ADDR_SPEED_HI = 8'h82;
  localparam logic [7:0] ADDR_SPEED_LO = 8'h83;
  localparam logic [7:0] ADDR_LOSS_THR = 8'h88;
  localparam logic [7:0] ADDR_OVER_THR = 8'h89;
  localparam logic [7:0] ADDR_MISM_THR = 8'h8a;
  localparam logic [7:0] ADDR_AMP_MAX = 8'h8b;
  localparam logic [7:0] ADDR_AMP_MIN = 8'h8c;
  localparam logic [7:0] ADDR_TRK_HIGH = 8'h8d;
  localparam logic [7:0] ADDR_TRK_LOW = 8'h8e;
  localparam logic [7:0] ADDR_EXC_FREQ = 8'h91;
  localparam logic [7:0] ADDR_CONTROL = 8'h92;
  localparam logic [7:0] ADDR_SOFT_RST = 8'hf0;
  localparam logic [7:0] ADDR_FAULT = 8'hff;
  localparam logic [7:0] RST_ADDR = 8'h80;
  // ----------------------------------------------------------------------
  // Storage slots of the read/write registers
  // ----------------------------------------------------------------------
  localparam int RW_COUNT = 9;
  localparam logic [3:0] IDX_LOSS = 4'h0;
  localparam logic [3:0] IDX_OVER = 4'h1;
  localparam logic [3:0] IDX_MISM = 4'h2;
  localparam logic [3:0] IDX_AMAX = 4'h3;
  localparam logic [3:0] IDX_AMIN = 4'h4;
  localparam logic [3:0] IDX_THIGH = 4'h5;
  localparam logic [3:0] IDX_TLOW = 4'h6;
  localparam logic [3:0] IDX_FCW = 4'h7;
  localparam logic [3:0] IDX_CTRL = 4'h8;
  localparam logic [3:0] IDX_NONE = 4'hf;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ADDR_FLAG_POS = 7;
  localparam int PARITY_POS = 7;
  localparam int CTRL_RESOLUTION_SELECT_LO_POS = 0;
  localparam int CTRL_RESOLUTION_SELECT_HI_POS = 1;
  localparam int CTRL_ENC_LSB = 2;
  localparam int CTRL_HYST_POS = 4;
  localparam int CTRL_PHASE_POS = 5;
  localparam int FAULT_PARITY_POS = 0;
  // ----------------------------------------------------------------------
  // Power-up values, 7 data bits each (38 mV steps for thresholds)
  // ----------------------------------------------------------------------
  localparam logic [6:0] RST_LOSS = 7'h3a;
  localparam logic [6:0] RST_OVER = 7'h6c;
  localparam logic [6:0] RST_MISM = 7'h0a;
  localparam logic [6:0] RST_AMAX = 7'h3c;
  localparam logic [6:0] RST_AMIN = 7'h69;
  localparam logic [6:0] RST_THIGH = 7'h24;
  localparam logic [6:0] RST_TLOW = 7'h07;
  localparam logic [6:0] RST_FCW = 7'h28;
  localparam logic [6:0] RST_CTRL = 7'h7e;
  // Excitation phase accumulator; output rate is word * f_clk / 2^15
  localparam int EXC_ACC_W = 15;
  // Velocity LSB weight scales with clock: 4.88/0.488/0.06/0.004 rps
  localparam longint CLK_HZ = 64'd50_000_000;
  // ----------------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_POSITION,
    MODE_VELOCITY,
    MODE_RESERVED,
    MODE_CONFIG
  } rdcfg_mode_e;
endpackage

// file: dv/rdcfg_host.sv
// Host model: mode pins and the byte strobe port of the bank.
// Assumes tasks are entered just after a rising edge of clk_in.
`timescale 1ns/1ps
module rdcfg_host
(
  input wire logic clk_in,
  input wire logic rd_valid_in,
  input wire logic [7:0] rd_data_in,
  output logic mode_select_lo_out,
  output logic mode_select_hi_out,
  output logic wr_strobe_out,
  output logic [7:0] wr_data_out,
  output logic rd_strobe_out
);
  // ------------------------------------------------------------------
  // Idle host in configuration mode
  // ------------------------------------------------------------------
  initial
  begin
    {mode_select_lo_out, mode_select_hi_out} = 2'b11;
    wr_strobe_out = 1'b0;
    wr_data_out = 8'h00;
    rd_strobe_out = 1'b0;
  end
  // Reserved code is refused here so no caller can apply it
  task automatic set_mode(input logic [1:0] m);
  begin
    @(posedge clk_in);
    if (m !== 2'b10)
      {mode_select_lo_out, mode_select_hi_out} <= m;
    repeat (3) @(posedge clk_in);
  end
  endtask
  // One strobe per byte, released a cycle before the next
  task automatic put_byte(input logic [7:0] b);
  begin
    @(posedge clk_in);
    wr_strobe_out <= 1'b1;
    wr_data_out <= b;
    @(posedge clk_in);
    wr_strobe_out <= 1'b0;
  end
  endtask
  // Address byte, then data with bit 7 low
  task automatic write_reg(input logic [7:0] a, input logic [6:0] d);
  begin
    put_byte(a);
    put_byte({1'b0, d});
  end
  endtask
  // Answer is taken one cycle after the strobe edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic v);
  begin
    put_byte(a);
    @(posedge clk_in);
    rd_strobe_out <= 1'b1;
    @(posedge clk_in);
    rd_strobe_out <= 1'b0;
    #1;
    v = rd_valid_in;
    d = rd_data_in;
  end
  endtask
endmodule

// file: dv/tb_rdcfg_bank.sv
// Self-checking bench for the configuration and readout bank.
// Assumes a 50 MHz clock; inputs change by NBA at rising edges.
`timescale 1ns/1ps
module tb_rdcfg_bank
  import rdcfg_pkg::*;
;
  localparam int LIMIT = 20000; // Far above the few thousand needed
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic sample = 1'b1; // Idles high so reset leaves no false fall
  logic en = 1'b1;
  logic res_lo = 1'b0; // Pins agree with control power-up bits
  logic res_hi = 1'b1;
  logic [15:0] angle = 16'h0000;
  logic [15:0] speed = 16'h0000;
  logic [7:0] fault = 8'h00;
  logic ml, mh, wr_s, rd_s, rd_v, cfg, exc, srst, fclr, hyst, v, seen, pln;
  logic [7:0] wr_d, rd_d, d;
  logic [15:0] dout, w;
  logic [1:0] res, enc;
  logic [6:0] loss_thr, over_thr, mism_thr, amax, amin, thi, tlo;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;
  logic [7:0] addr_tab [9] = '{ADDR_LOSS_THR, ADDR_OVER_THR,
    ADDR_MISM_THR, ADDR_AMP_MAX, ADDR_AMP_MIN, ADDR_TRK_HIGH,
    ADDR_TRK_LOW, ADDR_EXC_FREQ, ADDR_CONTROL};
  logic [6:0] rst_tab [9] = '{RST_LOSS, RST_OVER, RST_MISM, RST_AMAX,
    RST_AMIN, RST_THIGH, RST_TLOW, RST_FCW, RST_CTRL};
  always #10 clk_in = ~clk_in;
  // ------------------------------------------------------------------
  // Device and host
  // ------------------------------------------------------------------
  rdcfg_bank i_rdcfg_bank (.clk_in(clk_in), .reset_in(reset_in),
    .clk_en_in(en), .mode_select_lo_in(ml), .mode_select_hi_in(mh),
    .resolution_select_lo_in(res_lo), .resolution_select_hi_in(res_hi),
    .sample_in(sample), .angle_in(angle), .speed_in(speed),
    .fault_in(fault), .wr_strobe_in(wr_s), .wr_data_in(wr_d),
    .rd_strobe_in(rd_s), .rd_data_out(rd_d), .rd_valid_out(rd_v),
    .data_out(dout), .config_mode_out(cfg), .resolution_out(res),
    .encoder_resolution_out(enc), .hysteresis_out(hyst),
    .phase_lock_narrow_out(pln), .excitation_out(exc),
    .soft_reset_out(srst), .fault_cleared_out(fclr),
    .signal_loss_threshold_out(loss_thr),
    .overrange_threshold_out(over_thr),
    .mismatch_threshold_out(mism_thr), .amplitude_reset_max_out(amax),
    .amplitude_reset_min_out(amin), .tracking_high_threshold_out(thi),
    .tracking_low_threshold_out(tlo));
  rdcfg_host i_rdcfg_host (.clk_in(clk_in), .rd_valid_in(rd_v),
    .rd_data_in(rd_d), .mode_select_lo_out(ml), .mode_select_hi_out(mh),
    .wr_strobe_out(wr_s), .wr_data_out(wr_d), .rd_strobe_out(rd_s));
  // Comparison and verdict
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
  begin
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  task automatic print_verdict();
  begin
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // Two byte reads, high byte first
  task automatic rd16(input logic [7:0] a, output logic [15:0] r);
  begin
    i_rdcfg_host.read_reg(a, r[15:8], v);
    i_rdcfg_host.read_reg(a + 8'h01, r[7:0], v);
  end
  endtask
  // One low sample pulse, then time for the word to reach data_out
  task automatic fall(input logic [15:0] a, input logic [15:0] s);
  begin
    @(posedge clk_in);
    angle <= a;
    speed <= s;
    sample <= 1'b0;
    @(posedge clk_in);
    sample <= 1'b1;
    repeat (4) @(posedge clk_in);
  end
  endtask
  // Bounded wait for a level on the excitation output
  task automatic to_level(input logic lv);
  begin
    while (exc !== lv && n < 4000)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
  end
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      print_verdict();
    end
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    for (int i = 0; i < 9; i++)
    begin
      i_rdcfg_host.read_reg(addr_tab[i], d, v);
      check("default", {9'h000, rst_tab[i]}, {8'h00, d});
    end
    check("loss_thr", {9'h000, RST_LOSS}, {9'h000, loss_thr});
    check("over_thr", {9'h000, RST_OVER}, {9'h000, over_thr});
    check("mism_thr", {9'h000, RST_MISM}, {9'h000, mism_thr});
    for (int i = 0; i < 7; i++)
    begin
      i_rdcfg_host.write_reg(addr_tab[i], {i[2:0], 4'ha});
      i_rdcfg_host.read_reg(addr_tab[i], d, v);
      check("readback", {9'h000, i[2:0], 4'ha}, {8'h00, d});
    end
    check("loss_thr", 16'h000a, {9'h000, loss_thr});
    check("amax", 16'h003a, {9'h000, amax});
    check("amin", 16'h004a, {9'h000, amin});
    check("thi", 16'h005a, {9'h000, thi});
    check("tlo", 16'h006a, {9'h000, tlo});
    // Access outside configuration mode is ignored
    i_rdcfg_host.set_mode(2'b00);
    check("cfg_flag", 16'h0000, {15'h0000, cfg});
    i_rdcfg_host.write_reg(ADDR_LOSS_THR, 7'h55);
    i_rdcfg_host.read_reg(ADDR_LOSS_THR, d, v);
    check("rd_valid", 16'h0000, {15'h0000, v});
    i_rdcfg_host.set_mode(2'b11);
    check("cfg_flag", 16'h0001, {15'h0000, cfg});
    i_rdcfg_host.read_reg(ADDR_LOSS_THR, d, v);
    check("kept", 16'h000a, {8'h00, d});
    i_rdcfg_host.read_reg(8'h85, d, v);
    check("unmapped", 16'h0000, {8'h00, d});
    // Clock enable low: a full write sequence must leave no trace
    @(posedge clk_in);
    en <= 1'b0;
    i_rdcfg_host.write_reg(ADDR_LOSS_THR, 7'h11);
    en <= 1'b1;
    check("frozen", 16'h000a, {9'h000, loss_thr});
    // Sticky fault, cleared by its read
    @(posedge clk_in);
    fault <= 8'h80;
    @(posedge clk_in);
    fault <= 8'h00;
    i_rdcfg_host.read_reg(ADDR_FAULT, d, v);
    check("fault", 16'h0080, {8'h00, d});
    check("fault_clr", 16'h0001, {15'h0000, fclr});
    i_rdcfg_host.read_reg(ADDR_FAULT, d, v);
    check("fault", 16'h0000, {8'h00, d});
    // Sampled words: 12-bit with hysteresis, full, then 10-bit
    fall(16'habcd, 16'h7fff);
    rd16(ADDR_ANGLE_HI, w);
    check("angle", 16'habc0, w);
    rd16(ADDR_SPEED_HI, w);
    check("speed", 16'h7fff, w);
    i_rdcfg_host.write_reg(ADDR_CONTROL, 7'h6e);
    fall(16'h1235, 16'h8000);
    check("hyst", 16'h0000, {15'h0000, hyst});
    check("enc_pl", 16'h0007, {13'h0000, enc, pln});
    rd16(ADDR_ANGLE_HI, w);
    check("angle", 16'h1235, w);
    rd16(ADDR_SPEED_HI, w);
    check("speed", 16'h8000, w);
    i_rdcfg_host.write_reg(ADDR_CONTROL, 7'h50);
    fall(16'hffff, 16'h7fc0);
    check("res", 16'h0000, {14'h0000, res});
    check("enc_pl", 16'h0000, {13'h0000, enc, pln});
    rd16(ADDR_ANGLE_HI, w);
    check("angle", 16'hffc0, w);
    rd16(ADDR_SPEED_HI, w);
    check("speed", 16'h7fc0, w);
    // Normal mode, 14-bit from pins matching control bits
    i_rdcfg_host.write_reg(ADDR_CONTROL, 7'h51);
    @(posedge clk_in);
    res_lo <= 1'b1;
    res_hi <= 1'b0;
    i_rdcfg_host.set_mode(2'b00);
    fall(16'h5557, 16'hffc0);
    check("res", 16'h0002, {14'h0000, res});
    check("pos_out", 16'h5554, dout);
    i_rdcfg_host.set_mode(2'b01);
    check("vel_out", 16'hffc0, dout);
    // Soft reset pulse, then excitation period
    i_rdcfg_host.set_mode(2'b11);
    i_rdcfg_host.write_reg(ADDR_SOFT_RST, 7'h00);
    seen = 1'b0;
    repeat (3)
    begin
      #1;
      seen = seen | srst;
      @(posedge clk_in);
    end
    check("soft_rst", 16'h0001, {15'h0000, seen});
    i_rdcfg_host.write_reg(ADDR_EXC_FREQ, 7'h20);
    n = 0;
    to_level(1'b0);
    to_level(1'b1);
    n = 0;
    to_level(1'b0);
    to_level(1'b1);
    check("exc_period", 16'(32768 / 32), 16'(n));
    print_verdict();
  end
endmodule
